// ==== design/lgc_pkg.sv ====
package lgc_pkg;

    // Datapath widths
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int SIGN_BIT = 7;

    // Reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // Operation codes presented by the instruction decoder
    typedef enum logic [4:0] {
        OP_AND_AI  = 5'h00,
        OP_AND_AM  = 5'h01,
        OP_AND_MA  = 5'h02,
        OP_OR_AI   = 5'h03,
        OP_OR_AM   = 5'h04,
        OP_OR_MA   = 5'h05,
        OP_XOR_AI  = 5'h06,
        OP_XOR_AM  = 5'h07,
        OP_XOR_MA  = 5'h08,
        OP_XOR_IOA = 5'h09,
        OP_NOT_A   = 5'h0A,
        OP_NOT_M   = 5'h0B,
        OP_NEG_A   = 5'h0C,
        OP_NEG_M   = 5'h0D,
        OP_COMP_AM = 5'h0E,
        OP_COMP_MA = 5'h0F,
        OP_NONE    = 5'h1F
    } lgc_op_t;

    // Sequencer states, Gray coded along idle -> execute
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } lgc_state_t;

    // Status flags
    typedef struct packed {
        logic zero;
        logic carry;
        logic nibble_carry_flag;
        logic signed_wrap_flag;
    } lgc_flags_t;

    // One operation request with its operands
    typedef struct packed {
        lgc_op_t op;
        logic [7:0] imm;
        logic [7:0] ram_data;
        logic [7:0] port_a_data;
    } lgc_req_t;

    localparam lgc_req_t REQ_RST = '{OP_NONE, 8'h00, 8'h00, 8'h00};

endpackage

// ==== design/lgc_logic_unit.sv ====
`timescale 1ns/1ps

// Bitwise and complement result for every non-compare operation
module lgc_logic_unit
(
    input wire lgc_pkg::lgc_op_t op,
    input wire logic [7:0] working_register,
    input wire logic [7:0] imm,
    input wire logic [7:0] ram_data,
    input wire logic [7:0] port_a_data,
    output logic [7:0] result
);
    import lgc_pkg::*;

    // Operation select
    always_comb
    begin
        case (op)
            OP_AND_AI: result = working_register & imm;
            OP_AND_AM, OP_AND_MA: result = working_register & ram_data;
            OP_OR_AI: result = working_register | imm;
            OP_OR_AM, OP_OR_MA: result = working_register | ram_data;
            OP_XOR_AI: result = working_register ^ imm;
            OP_XOR_AM, OP_XOR_MA: result = working_register ^ ram_data;
            OP_XOR_IOA: result = working_register ^ port_a_data;
            OP_NOT_A: result = ~working_register;
            OP_NOT_M: result = ~ram_data;
            OP_NEG_A: result = 8'(ZERO_BYTE - working_register);
            OP_NEG_M: result = 8'(ZERO_BYTE - ram_data);
            default: result = ZERO_BYTE;
        endcase
    end

endmodule

// ==== design/lgc_sub_flags.sv ====
`timescale 1ns/1ps

// Flags of minuend minus subtrahend; the difference itself is dropped
module lgc_sub_flags
(
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    output lgc_pkg::lgc_flags_t flags
);
    import lgc_pkg::*;

    logic [8:0] diff;
    logic [4:0] nib_diff;

    // Widened subtraction exposes the borrows
    always_comb
    begin
        diff = {1'b0, minuend} - {1'b0, subtrahend};
        nib_diff = {1'b0, minuend[NIB_W-1:0]} - {1'b0, subtrahend[NIB_W-1:0]};
        flags.zero = (diff[DATA_W-1:0] == ZERO_BYTE);
        flags.carry = diff[DATA_W];
        flags.nibble_carry_flag = nib_diff[NIB_W];
        flags.signed_wrap_flag = (minuend[SIGN_BIT] != subtrahend[SIGN_BIT])
            && (diff[SIGN_BIT] != minuend[SIGN_BIT]);
    end

endmodule

// ==== design/lgc_logic_alu.sv ====
// Behaviour
// RL1 - AND forms: result to working register, or RAM for RAM destination; zero only.
// RL2 - OR forms: result to working register, or RAM for RAM destination; zero only.
// RL3 - XOR with immediate or RAM source writes working register; zero flag only.
// RL4 - XOR with RAM destination writes result back into that RAM location.
// RL5 - XOR with I/O destination writes back to the I/O register; no flag changes.
// RL6 - One's complement of working register; zero flag only.
// RL7 - One's complement of RAM location; zero flag only.
// RL8 - Two's complement of working register; zero flag only.
// RL9 - Two's complement of RAM location; zero flag only.
// RL10 - Register-minus-RAM compare sets all four flags, writes nothing.
// RL11 - RAM-minus-register compare sets all four flags, writes nothing.
// RL12 - Equal compare operands set the zero flag.
// RL13 - Register below RAM operand in compare sets the borrow flag.
// RL14 - Eight-bit operands; zero flag set exactly when result is zero.
`timescale 1ns/1ps

module lgc_logic_alu
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic op_valid,
    input wire lgc_pkg::lgc_req_t op_req,
    input wire logic wreg_load,
    input wire logic [7:0] wreg_load_data,
    output logic busy_ff,
    output logic done_ff,
    output logic [7:0] working_register_ff,
    output lgc_pkg::lgc_flags_t flags_ff,
    output logic ram_wr_en_ff,
    output logic [7:0] ram_wdata_ff,
    output logic io_wr_en_ff,
    output logic [7:0] io_wdata_ff
);
    import lgc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Request capture and sequencing

    lgc_state_t state_ff;
    lgc_state_t nxt_state;
    lgc_req_t req_ff;
    lgc_req_t nxt_req;
    logic nxt_busy;

    // Take a request in idle, execute it on the next enabled edge
    always_comb
    begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_busy = busy_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (op_valid)
                begin
                    nxt_state = ST_EXEC;
                    nxt_req = op_req;
                    nxt_busy = 1'b1;
                end
            end
            ST_EXEC:
            begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_ff <= ST_IDLE;
            req_ff <= REQ_RST;
            busy_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            busy_ff <= nxt_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath

    logic [7:0] logic_result;
    logic [7:0] cmp_minuend;
    logic [7:0] cmp_subtrahend;
    lgc_flags_t cmp_flags;
    logic exec;

    assign exec = (state_ff == ST_EXEC);

    lgc_logic_unit u_logic
    (
        .op(req_ff.op),
        .working_register(working_register_ff),
        .imm(req_ff.imm),
        .ram_data(req_ff.ram_data),
        .port_a_data(req_ff.port_a_data),
        .result(logic_result)
    );

    // RL11 operand swap
    always_comb
    begin
        if (req_ff.op == OP_COMP_MA)
        begin
            cmp_minuend = req_ff.ram_data;
            cmp_subtrahend = working_register_ff;
        end
        else
        begin
            cmp_minuend = working_register_ff;
            cmp_subtrahend = req_ff.ram_data;
        end
    end

    lgc_sub_flags u_cmp
    (
        .minuend(cmp_minuend),
        .subtrahend(cmp_subtrahend),
        .flags(cmp_flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Result write-back and flags

    logic [7:0] nxt_wreg;
    lgc_flags_t nxt_flags;
    logic nxt_ram_wr_en;
    logic [7:0] nxt_ram_wdata;
    logic nxt_io_wr_en;
    logic [7:0] nxt_io_wdata;
    logic nxt_done;

    // Route result to its destination and update flags per operation
    always_comb
    begin
        nxt_wreg = working_register_ff;
        nxt_flags = flags_ff;
        nxt_ram_wr_en = 1'b0;
        nxt_ram_wdata = ram_wdata_ff;
        nxt_io_wr_en = 1'b0;
        nxt_io_wdata = io_wdata_ff;
        nxt_done = 1'b0;
        if (exec)
        begin
            nxt_done = 1'b1;
            case (req_ff.op)
                // RL1 RL2 RL3 RL6 RL8 register destination
                OP_AND_AI, OP_AND_AM, OP_OR_AI, OP_OR_AM, OP_XOR_AI, OP_XOR_AM,
                OP_NOT_A, OP_NEG_A:
                begin
                    nxt_wreg = logic_result;
                    // RL14 zero on result
                    nxt_flags.zero = (logic_result == ZERO_BYTE);
                end
                // RL1 RL2 RL4 RL7 RL9 RAM destination
                OP_AND_MA, OP_OR_MA, OP_XOR_MA, OP_NOT_M, OP_NEG_M:
                begin
                    nxt_ram_wr_en = 1'b1;
                    nxt_ram_wdata = logic_result;
                    nxt_flags.zero = (logic_result == ZERO_BYTE);
                end
                // RL5 port write, flags kept
                OP_XOR_IOA:
                begin
                    nxt_io_wr_en = 1'b1;
                    nxt_io_wdata = logic_result;
                end
                // RL10 RL11 RL12 RL13 compare flags
                OP_COMP_AM, OP_COMP_MA:
                begin
                    nxt_flags = cmp_flags;
                end
                default:
                begin
                    nxt_done = 1'b1;
                end
            endcase
        end
        else if (wreg_load)
        begin
            nxt_wreg = wreg_load_data;
        end
    end

    // Result registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            working_register_ff <= WREG_RST;
            flags_ff <= FLAGS_RST;
            ram_wr_en_ff <= 1'b0;
            ram_wdata_ff <= DATA_RST;
            io_wr_en_ff <= 1'b0;
            io_wdata_ff <= DATA_RST;
            done_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            working_register_ff <= nxt_wreg;
            flags_ff <= nxt_flags;
            ram_wr_en_ff <= nxt_ram_wr_en;
            ram_wdata_ff <= nxt_ram_wdata;
            io_wr_en_ff <= nxt_io_wr_en;
            io_wdata_ff <= nxt_io_wdata;
            done_ff <= nxt_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic fire;
    assign fire = exec && clk_en;

    // RL1 AND into register
    a_and_imm_result: assert property (@(posedge clk_sys) disable iff (reset) // RL1
        fire && req_ff.op == OP_AND_AI |=> working_register_ff ==
        ($past(working_register_ff) & $past(req_ff.imm)) && !ram_wr_en_ff
        && flags_ff[2:0] == $past(flags_ff[2:0]))
        else $error("AND immediate result or flags wrong");

    // RL2 OR into RAM
    a_or_ram_dest: assert property (@(posedge clk_sys) disable iff (reset) // RL2
        fire && req_ff.op == OP_OR_MA |=> ram_wr_en_ff && ram_wdata_ff ==
        ($past(working_register_ff) | $past(req_ff.ram_data))
        && working_register_ff == $past(working_register_ff))
        else $error("OR to RAM wrong");

    // RL3 XOR keeps other flags
    a_xor_flags_kept: assert property (@(posedge clk_sys) disable iff (reset) // RL3
        fire && req_ff.op == OP_XOR_AM |=> flags_ff.carry == $past(flags_ff.carry)
        && flags_ff.nibble_carry_flag == $past(flags_ff.nibble_carry_flag)
        && flags_ff.signed_wrap_flag == $past(flags_ff.signed_wrap_flag)
        && working_register_ff == ($past(working_register_ff) ^ $past(req_ff.ram_data)))
        else $error("XOR from RAM wrong");

    // RL4 XOR back to RAM
    a_xor_ram_back: assert property (@(posedge clk_sys) disable iff (reset) // RL4
        fire && req_ff.op == OP_XOR_MA |=> ram_wr_en_ff
        && ram_wdata_ff == ($past(working_register_ff) ^ $past(req_ff.ram_data))
        ##1 !ram_wr_en_ff || !$past(clk_en))
        else $error("XOR to RAM write wrong");

    // RL5 port write with no flag change
    a_xor_port_write: assert property (@(posedge clk_sys) disable iff (reset) // RL5
        fire && req_ff.op == OP_XOR_IOA |=> io_wr_en_ff && flags_ff == $past(flags_ff)
        && io_wdata_ff == ($past(working_register_ff) ^ $past(req_ff.port_a_data)))
        else $error("XOR to port wrong");

    // RL6 one's complement of register
    a_not_wreg: assert property (@(posedge clk_sys) disable iff (reset) // RL6
        fire && req_ff.op == OP_NOT_A |=> working_register_ff == ~$past(working_register_ff))
        else $error("NOT register wrong");

    // RL7 one's complement of RAM
    a_not_ram: assert property (@(posedge clk_sys) disable iff (reset) // RL7
        fire && req_ff.op == OP_NOT_M |=> ram_wr_en_ff && ram_wdata_ff == ~$past(req_ff.ram_data)
        && flags_ff[2:0] == $past(flags_ff[2:0]))
        else $error("NOT RAM wrong");

    // RL8 negation of register
    a_neg_wreg: assert property (@(posedge clk_sys) disable iff (reset) // RL8
        fire && req_ff.op == OP_NEG_A |=>
        8'(working_register_ff + $past(working_register_ff)) == ZERO_BYTE)
        else $error("NEG register wrong");

    // RL9 negation of RAM
    a_neg_ram: assert property (@(posedge clk_sys) disable iff (reset) // RL9
        fire && req_ff.op == OP_NEG_M |=> ram_wr_en_ff
        && 8'(ram_wdata_ff + $past(req_ff.ram_data)) == ZERO_BYTE)
        else $error("NEG RAM wrong");

    // RL10 compare writes nothing
    a_cmp_no_write: assert property (@(posedge clk_sys) disable iff (reset) // RL10
        fire && (req_ff.op == OP_COMP_AM || req_ff.op == OP_COMP_MA) |=>
        !ram_wr_en_ff && !io_wr_en_ff && working_register_ff == $past(working_register_ff))
        else $error("Compare wrote an operand");

    // RL11 reversed compare borrow
    a_cmp_rev_borrow: assert property (@(posedge clk_sys) disable iff (reset) // RL11
        fire && req_ff.op == OP_COMP_MA |=>
        flags_ff.carry == ($past(req_ff.ram_data) < $past(working_register_ff)))
        else $error("Reversed compare borrow wrong");

    // RL12 equal compare
    a_cmp_equal: assert property (@(posedge clk_sys) disable iff (reset) // RL12
        fire && req_ff.op == OP_COMP_AM && working_register_ff == req_ff.ram_data
        |=> flags_ff.zero && !flags_ff.carry)
        else $error("Equal compare zero flag wrong");

    // RL13 borrow on smaller register
    a_cmp_borrow: assert property (@(posedge clk_sys) disable iff (reset) // RL13
        fire && req_ff.op == OP_COMP_AM |=>
        flags_ff.carry == ($past(working_register_ff) < $past(req_ff.ram_data)))
        else $error("Compare borrow wrong");

    // RL14 zero flag follows written result
    a_zero_tracks: assert property (@(posedge clk_sys) disable iff (reset) // RL14
        fire && (req_ff.op == OP_AND_AM || req_ff.op == OP_OR_AI) |=>
        flags_ff.zero == (working_register_ff == ZERO_BYTE))
        else $error("Zero flag mismatch");

    // Busy follows acceptance by one enabled edge, with done still low until the next
    a_done_timing: assert property (@(posedge clk_sys) disable iff (reset)
        state_ff == ST_IDLE && clk_en && op_valid |=> busy_ff && !done_ff)
        else $error("Acceptance did not raise busy");

endmodule

// ==== sim/lgc_mem_model.sv ====
`timescale 1ns/1ps

// Data memory and port A register seen by the block
module lgc_mem_model
#(
    parameter logic [7:0] MEM_INIT = 8'h00,
    parameter logic [7:0] PORT_INIT = 8'h5a
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ld_en,
    input wire logic [7:0] ld_data,
    input wire logic ram_wr_en,
    input wire logic [7:0] ram_wdata,
    input wire logic io_wr_en,
    input wire logic [7:0] io_wdata,
    output logic [7:0] mem_byte,
    output logic [7:0] port_byte
);
    ////////////////////////////////////////////////////////////////
    // Store block writes and bench preloads; writes win
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            mem_byte <= MEM_INIT;
            port_byte <= PORT_INIT;
        end
        else
        begin
            if (ram_wr_en)
                mem_byte <= ram_wdata;
            else if (ld_en)
                mem_byte <= ld_data;
            if (io_wr_en)
                port_byte <= io_wdata;
        end
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end

module tb_top;
    import lgc_pkg::*;

    typedef struct packed {
        logic [7:0] w;
        lgc_flags_t f;
        logic rwe;
        logic [7:0] rd;
        logic iwe;
        logic [7:0] id;
    } lgc_exp_t;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic op_valid = 1'b0;
    lgc_req_t op_req = REQ_RST;
    logic wreg_load = 1'b0;
    logic [7:0] wreg_load_data = 8'h00;
    logic ld_en = 1'b0;
    logic [7:0] ld_data = 8'h00;
    logic busy_ff;
    logic done_ff;
    logic [7:0] working_register_ff;
    lgc_flags_t flags_ff;
    logic ram_wr_en_ff;
    logic [7:0] ram_wdata_ff;
    logic io_wr_en_ff;
    logic [7:0] io_wdata_ff;
    logic [7:0] mem_byte;
    logic [7:0] port_byte;
    lgc_exp_t exp_q[$];
    lgc_exp_t n;
    logic [7:0] exp_w = WREG_RST;
    lgc_flags_t exp_f = FLAGS_RST;
    logic done_prev = 1'b0;
    logic [31:0] rv;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 79509;

    always #12.5 clk_sys = ~clk_sys;

    lgc_logic_alu u_lgc_logic_alu (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
        .op_valid(op_valid), .op_req(op_req), .wreg_load(wreg_load),
        .wreg_load_data(wreg_load_data), .busy_ff(busy_ff), .done_ff(done_ff),
        .working_register_ff(working_register_ff), .flags_ff(flags_ff),
        .ram_wr_en_ff(ram_wr_en_ff), .ram_wdata_ff(ram_wdata_ff),
        .io_wr_en_ff(io_wr_en_ff), .io_wdata_ff(io_wdata_ff));

    lgc_mem_model u_lgc_mem_model (.clk_sys(clk_sys), .reset(reset), .ld_en(ld_en),
        .ld_data(ld_data), .ram_wr_en(ram_wr_en_ff), .ram_wdata(ram_wdata_ff),
        .io_wr_en(io_wr_en_ff), .io_wdata(io_wdata_ff), .mem_byte(mem_byte),
        .port_byte(port_byte));

    ////////////////////////////////////////////////////////////////
    // Flags of x minus y, worked out independently
    function automatic lgc_flags_t sub_flags(input logic [7:0] x, input logic [7:0] y);
        logic [7:0] d;
        d = x - y;
        return '{d == 8'h00, x < y, x[3:0] < y[3:0], (x[7] != y[7]) && (d[7] != x[7])};
    endfunction

    // Verdict and end of run
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Working register preload
    task automatic load_w(input logic [7:0] v);
        @(posedge clk_sys);
        #2;
        wreg_load = 1'b1;
        wreg_load_data = v;
        exp_w = v;
        @(posedge clk_sys);
        #2;
        wreg_load = 1'b0;
        `CHK(working_register_ff, v)
    endtask

    // Memory preload through the partner
    task automatic load_m(input logic [7:0] v);
        @(posedge clk_sys);
        #2;
        ld_en = 1'b1;
        ld_data = v;
        @(posedge clk_sys);
        #2;
        ld_en = 1'b0;
    endtask

    // One operation: note the expectation, offer, optional stall and held request
    task automatic run_op(input logic [4:0] code, input logic [7:0] imm, input int stall,
                          input logic hold);
        lgc_exp_t e;
        logic [7:0] m;
        logic [7:0] r;
        // Operands read after the last write-back has landed in the partner
        @(posedge clk_sys);
        #2;
        m = mem_byte;
        e = '{exp_w, exp_f, 1'b0, 8'h00, 1'b0, 8'h00};
        case (code)
            5'h00: r = exp_w & imm;
            5'h01, 5'h02: r = exp_w & m;
            5'h03: r = exp_w | imm;
            5'h04, 5'h05: r = exp_w | m;
            5'h06: r = exp_w ^ imm;
            5'h07, 5'h08: r = exp_w ^ m;
            5'h09: r = exp_w ^ port_byte;
            5'h0A: r = ~exp_w;
            5'h0B: r = ~m;
            5'h0C: r = -exp_w;
            5'h0D: r = -m;
            default: r = 8'h00;
        endcase
        if (code inside {5'h00, 5'h01, 5'h03, 5'h04, 5'h06, 5'h07, 5'h0A, 5'h0C})
            e.w = r;
        if (code inside {5'h02, 5'h05, 5'h08, 5'h0B, 5'h0D})
            e = '{exp_w, exp_f, 1'b1, r, 1'b0, 8'h00};
        if (code == 5'h09)
            e.iwe = 1'b1;
        e.id = r;
        if (code <= 5'h0D && code != 5'h09)
            e.f.zero = (r == 8'h00);
        if (code == 5'h0E)
            e.f = sub_flags(exp_w, m);
        if (code == 5'h0F)
            e.f = sub_flags(m, exp_w);
        exp_w = e.w;
        exp_f = e.f;
        op_valid = 1'b1;
        op_req = '{lgc_op_t'(code), imm, m, port_byte};
        exp_q.push_back(e);
        @(posedge clk_sys);
        #2;
        op_valid = hold;
        `CHK(busy_ff, 1'b1)
        if (stall > 0)
        begin
            clk_en = 1'b0;
            repeat (stall) @(posedge clk_sys);
            #2;
            clk_en = 1'b1;
        end
        @(posedge clk_sys);
        #2;
        op_valid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // Result watcher: oldest note against each new completion
    always @(posedge clk_sys)
    begin
        #1;
        if (done_ff === 1'b1 && !done_prev)
        begin
            if (exp_q.size() == 0)
            begin
                fail_count++;
                $display("ERROR at %0t: completion with no request", $time);
            end
            else
            begin
                n = exp_q.pop_front();
                `CHK(working_register_ff, n.w)
                `CHK(flags_ff, n.f)
                `CHK(ram_wr_en_ff, n.rwe)
                `CHK(io_wr_en_ff, n.iwe)
                if (n.rwe)
                    `CHK(ram_wdata_ff, n.rd)
                if (n.iwe)
                    `CHK(io_wdata_ff, n.id)
            end
        end
        done_prev = (done_ff === 1'b1);
    end

    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            $display("ERROR at %0t: run timed out", $time);
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        #2;
        reset = 1'b0;
        `CHK(working_register_ff, WREG_RST)
        load_w(8'h38);
        load_m(8'h38);
        run_op(5'h0E, 8'h00, 0, 1'b0);
        load_m(8'h42);
        run_op(5'h0E, 8'h00, 0, 1'b0);
        run_op(5'h0F, 8'h00, 0, 1'b0);
        load_w(8'h80);
        load_m(8'h01);
        run_op(5'h0E, 8'h00, 0, 1'b0);
        load_w(8'h00);
        run_op(5'h0C, 8'h00, 0, 1'b0);
        load_w(8'hff);
        run_op(5'h0A, 8'h00, 0, 1'b0);
        run_op(5'h00, 8'h00, 0, 1'b0);
        // port write with held request and stall, then undefined code 5'h10 with a stall
        load_w(8'h3c);
        run_op(5'h09, 8'h00, 3, 1'b1);
        run_op(5'h10, 8'h55, 2, 1'b0);
        // Random sweep over operation codes 5'h00 to 5'h0F
        repeat (12)
        begin
            for (int c = 0; c < 16; c++)
            begin
                rv = $random(seed);
                if (rv[11])
                    load_w(rv[19:12]);
                if (rv[12])
                    load_m(rv[27:20]);
                run_op(5'(c), rv[7:0], (rv[9:8] == 2'b11) ? 2 : 0, rv[10]);
            end
        end
        repeat (4) @(posedge clk_sys);
        if (exp_q.size() != 0)
        begin
            fail_count++;
            $display("ERROR at %0t: missing completions", $time);
        end
        end_sim();
    end
endmodule
